// ===== hw/sfe_prot.sv
// Block protection check: is a 64 KByte block covered by the protect bits
`timescale 1ns/1ps
module sfe_prot
  import sfe_pkg::*;
(
  sfe_prot_if.chk pif
);
  logic [3:0] count;

  // Level 0 none, 1..3 one eighth to one half, 4 and up the whole array
  always_comb begin
    if (pif.bp == 3'h0) begin
      count = 4'h0;
    end else if (pif.bp[2]) begin
      count = 4'h8;
    end else begin
      count = 4'h1 << (pif.bp - 3'h1);
    end
    if (pif.tb) begin
      pif.hit = ({1'b0, pif.blk} < count);
    end else begin
      pif.hit = (count != 4'h0) && ({1'b0, pif.blk} >= (4'h8 - count));
    end
  end
endmodule : sfe_prot

// ===== hw/sfe_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // Only the second stage is read by anything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sfe_sync

// ===== hw/sfe_top.sv
// Serial flash bus front end: framing, hold, status, protection, erase requests
// Summary of operation
// - Inputs captured on serial clock rising edge
// - Output bits change after serial clock falling edge
// - Selection starts only on chip select fall
// - Chip select high: deselected, standby, bus ignored
// - Both clock idle levels, modes 0 and 3
// - 3B dual output read, BB dual io read
// - Dual mode: both lines in and out
// - Hold suspends sequence keeping its place
// - Write protect pin gates the lock bit
// - Busy bit shows erase in progress; polled
// - Protected blocks refuse erase
// - Sector erase: aligned 4 KByte
// - Block erase: aligned 64 KByte
// - Hold edges count only while clock low
// - Held: output floats, inputs ignored
// - Busy bit 0, latch bit 1, reset zero
`timescale 1ns/1ps
module sfe_top
  import sfe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic io0_in,
  output logic io0_out,
  output logic io0_oe,
  input wire logic io1_in,
  output logic io1_out,
  output logic io1_oe,
  input wire logic array_busy,
  input wire logic [7:0] rd_data,
  output logic [SFE_ADDR_W-1:0] rd_addr,
  output logic erase_sector,
  output logic erase_block,
  output logic [SFE_ADDR_W-1:0] erase_addr,
  output logic standby
);
  logic sck_s, cs_s, hold_s, wp_s, io0_s, io1_s;
  logic sck_prev, cs_prev, hold_prev;
  logic next_sck_prev, next_cs_prev, next_hold_prev;
  sfe_state_type state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt, ocnt, next_ocnt;
  logic [1:0] byte_cnt, next_byte_cnt;
  logic [7:0] shift_in, next_shift_in, shift_out, next_shift_out, opcode, next_opcode;
  logic dual_in, next_dual_in, dual_out, next_dual_out, held, next_held, drv, next_drv;
  logic write_enable_latch, next_wel, tb, next_tb, protect_lock_bit, next_bpl;
  logic [2:0] bp, next_bp;
  logic [SFE_ADDR_W-1:0] next_rd_addr, next_erase_addr, new_addr;
  logic next_erase_sector, next_erase_block, next_standby;
  logic next_io0_out, next_io1_out, next_io0_oe, next_io1_oe;
  logic sck_rise, sck_fall, cs_fall, hold_fall, hold_rise, byte_done, may_write;
  logic [7:0] rx_byte, tx_byte, status_byte;

  // Reset levels match the idle pins: chip select, hold and protect high, so no false edge
  sfe_sync #(.W(6), .RST_VAL(6'h1C)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({sck, cs_n, hold_n, wp_n, io0_in, io1_in}),
    .dout({sck_s, cs_s, hold_s, wp_s, io0_s, io1_s})
  );

  sfe_prot_if pif ();
  sfe_prot u_prot (.pif(pif.chk));

  // Edge detection on the sampled clock works for either idle level
  assign sck_rise = sck_s && !sck_prev;
  assign sck_fall = !sck_s && sck_prev;
  assign cs_fall = cs_prev && !cs_s;
  assign hold_fall = hold_prev && !hold_s;
  assign hold_rise = !hold_prev && hold_s;
  assign byte_done = bit_cnt == (dual_in ? SFE_LAST_BIT_DUAL : SFE_LAST_BIT_SINGLE);
  assign rx_byte = dual_in ? {shift_in[5:0], io1_s, io0_s} : {shift_in[6:0], io0_s};
  assign new_addr = {rd_addr[SFE_ADDR_W-9:0], rx_byte};
  assign status_byte = {protect_lock_bit, 1'b0, tb, bp, write_enable_latch, array_busy};
  assign tx_byte = (ocnt != 3'h0) ? shift_out : (state == SFE_STAT) ? status_byte : rd_data;
  assign may_write = write_enable_latch && (wp_s || !protect_lock_bit);
  assign pif.bp = bp;
  assign pif.tb = tb;
  assign pif.blk = new_addr[SFE_BLK_LSB +: SFE_BLK_W];

  always_comb begin
    next_sck_prev = sck_s;
    next_cs_prev = cs_s;
    next_hold_prev = hold_s;
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_ocnt = ocnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_opcode = opcode;
    next_dual_in = dual_in;
    next_dual_out = dual_out;
    next_held = held;
    next_drv = drv;
    next_wel = write_enable_latch;
    next_bp = bp;
    next_tb = tb;
    next_bpl = protect_lock_bit;
    next_rd_addr = rd_addr;
    next_erase_addr = erase_addr;
    next_erase_sector = 1'b0;
    next_erase_block = 1'b0;
    next_io0_out = io0_out;
    next_io1_out = io1_out;
    next_standby = cs_s;
    if (cs_s) begin
      next_held = 1'b0;
    end else if (!held && hold_fall && !sck_s) begin
      next_held = 1'b1;
    end else if (held && hold_rise && !sck_s) begin
      next_held = 1'b0;
    end
    if (cs_s) begin
      // A rise of chip select mid-sequence abandons it
      next_state = SFE_IDLE;
      next_bit_cnt = 3'h0;
      next_byte_cnt = 2'h0;
      next_ocnt = 3'h0;
      next_dual_in = 1'b0;
      next_dual_out = 1'b0;
      next_drv = 1'b0;
    end else if (cs_fall) begin
      next_state = SFE_CMD;
    end else if (!held && sck_rise && (state == SFE_CMD || state == SFE_ADDR ||
                 state == SFE_DUMMY || state == SFE_WRSR)) begin
      next_shift_in = rx_byte;
      next_bit_cnt = bit_cnt + (dual_in ? SFE_BITS_TWO : SFE_BITS_ONE);
      if (byte_done) begin
        unique case (state)
          SFE_CMD: begin
            next_opcode = rx_byte;
            next_state = SFE_IGN;
            // While busy only the status read is taken
            if (rx_byte == SFE_OP_RDSR) begin
              next_state = SFE_STAT;
            end else if (!array_busy) begin
              unique case (rx_byte)
                SFE_OP_WREN: next_wel = 1'b1;
                SFE_OP_WRDI: next_wel = 1'b0;
                SFE_OP_WRSR: next_state = SFE_WRSR;
                SFE_OP_SE, SFE_OP_BE, SFE_OP_FRD_DO: next_state = SFE_ADDR;
                SFE_OP_FRD_DIO: begin
                  next_state = SFE_ADDR;
                  next_dual_in = 1'b1;
                end
                default: next_state = SFE_IGN;
              endcase
            end
          end
          SFE_ADDR: begin
            next_rd_addr = new_addr;
            next_byte_cnt = byte_cnt + 2'h1;
            if (byte_cnt == SFE_ADDR_LAST) begin
              if (opcode == SFE_OP_SE || opcode == SFE_OP_BE) begin
                next_state = SFE_IGN;
                next_wel = 1'b0;
                next_erase_sector = (opcode == SFE_OP_SE) && write_enable_latch && !pif.hit;
                next_erase_block = (opcode == SFE_OP_BE) && write_enable_latch && !pif.hit;
                next_erase_addr = new_addr & ((opcode == SFE_OP_SE) ?
                                  SFE_SECTOR_MASK : SFE_BLOCK_MASK);
              end else begin
                next_state = SFE_DUMMY;
              end
            end
          end
          SFE_DUMMY: begin
            next_state = SFE_DOUT;
            next_dual_in = 1'b0;
            next_dual_out = 1'b1;
          end
          SFE_WRSR: begin
            next_state = SFE_IGN;
            next_wel = 1'b0;
            if (may_write) begin
              next_bp = rx_byte[SFE_ST_BP_LSB +: 3];
              next_tb = rx_byte[SFE_ST_TB];
              next_bpl = rx_byte[SFE_ST_BPL];
            end
          end
          default: next_state = SFE_IGN;
        endcase
      end
    end else if (!held && sck_fall && (state == SFE_DOUT || state == SFE_STAT)) begin
      // The array has many system clocks between serial edges to settle
      next_drv = 1'b1;
      next_io1_out = tx_byte[7];
      if (dual_out) begin
        next_io0_out = tx_byte[6];
        next_shift_out = {tx_byte[5:0], 2'b00};
        next_ocnt = ocnt + SFE_BITS_TWO;
      end else begin
        next_shift_out = {tx_byte[6:0], 1'b0};
        next_ocnt = ocnt + SFE_BITS_ONE;
      end
      if (ocnt == 3'h0 && state == SFE_DOUT) begin
        next_rd_addr = rd_addr + {{(SFE_ADDR_W-1){1'b0}}, 1'b1};
      end
    end
    next_io1_oe = !cs_s && !next_held && next_drv;
    next_io0_oe = !cs_s && !next_held && next_drv && next_dual_out;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
      hold_prev <= 1'b1;
      state <= SFE_IDLE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      ocnt <= 3'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      opcode <= 8'h00;
      dual_in <= 1'b0;
      dual_out <= 1'b0;
      held <= 1'b0;
      drv <= 1'b0;
      write_enable_latch <= SFE_WEL_RESET;
      bp <= SFE_BP_RESET;
      tb <= SFE_TB_RESET;
      protect_lock_bit <= SFE_BPL_RESET;
      rd_addr <= '0;
      erase_addr <= '0;
      erase_sector <= 1'b0;
      erase_block <= 1'b0;
      io0_out <= 1'b0;
      io1_out <= 1'b0;
      io0_oe <= 1'b0;
      io1_oe <= 1'b0;
      standby <= 1'b1;
    end else begin
      sck_prev <= next_sck_prev;
      cs_prev <= next_cs_prev;
      hold_prev <= next_hold_prev;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      ocnt <= next_ocnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      opcode <= next_opcode;
      dual_in <= next_dual_in;
      dual_out <= next_dual_out;
      held <= next_held;
      drv <= next_drv;
      write_enable_latch <= next_wel;
      bp <= next_bp;
      tb <= next_tb;
      protect_lock_bit <= next_bpl;
      rd_addr <= next_rd_addr;
      erase_addr <= next_erase_addr;
      erase_sector <= next_erase_sector;
      erase_block <= next_erase_block;
      io0_out <= next_io0_out;
      io1_out <= next_io1_out;
      io0_oe <= next_io0_oe;
      io1_oe <= next_io1_oe;
      standby <= next_standby;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  standby_float_a: assert property (cs_s |=> (state == SFE_IDLE && !io1_oe && !io0_oe))
    else $error("deselected device still active");
  select_edge_a: assert property (state == SFE_IDLE && !cs_fall |=> state == SFE_IDLE)
    else $error("left standby without chip select fall");
  capture_rise_a: assert property ($changed(shift_in) |-> $past(sck_rise))
    else $error("input shifted without rising edge");
  msb_first_a: assert property (sck_rise && !held && !dual_in && state == SFE_CMD
    |=> shift_in[0] == $past(io0_s) && shift_in[7:1] == $past(shift_in[6:0]))
    else $error("input not shifted most significant first");
  out_fall_a: assert property (io1_oe && $past(io1_oe) && $changed(io1_out)
    |-> $past(sck_fall))
    else $error("output changed away from falling edge");
  hold_entry_a: assert property ($rose(held) |-> $past(hold_fall && !sck_s && !cs_s))
    else $error("hold entered on a bad edge");
  hold_float_a: assert property (held |-> !io1_oe && !io0_oe)
    else $error("output driven while held");
  hold_keep_a: assert property ((held && !cs_s) ##1 (held && !cs_s)
    |-> $stable(bit_cnt) && $stable(state) && $stable(ocnt))
    else $error("sequence moved while held");
  dual_decode_a: assert property (state == SFE_CMD && sck_rise && !held && !cs_s && byte_done
    && !array_busy && rx_byte == SFE_OP_FRD_DIO |=> state == SFE_ADDR && dual_in)
    else $error("dual io read not decoded");
  dual_drive_a: assert property (io0_oe |-> dual_out && state == SFE_DOUT)
    else $error("second line driven outside dual data");
  lock_hold_a: assert property (state == SFE_WRSR && sck_rise && !held && !cs_s && byte_done
    && !wp_s && protect_lock_bit |=> $stable(bp) && $stable(tb) && protect_lock_bit)
    else $error("locked status register altered");
  busy_refuse_a: assert property (state == SFE_CMD && sck_rise && !held && !cs_s && byte_done
    && array_busy && rx_byte != SFE_OP_RDSR |=> state == SFE_IGN)
    else $error("command taken while busy");
  erase_prot_a: assert property (erase_sector || erase_block |-> $past(write_enable_latch && !pif.hit))
    else $error("erase of protected or disabled region");
  sector_align_a: assert property (erase_sector |-> erase_addr[11:0] == 12'h000)
    else $error("sector erase not aligned");
  block_align_a: assert property (erase_block |-> erase_addr[15:0] == 16'h0000)
    else $error("block erase not aligned");
  wel_reset_a: assert property ($past(rst) |-> !write_enable_latch && !status_byte[SFE_ST_WEL])
    else $error("write enable latch set after reset");

  dual_read_c: cover property (state == SFE_DOUT && io0_oe && io1_oe);
  hold_seen_c: cover property (held ##1 !held && !cs_s);
  erase_go_c: cover property (erase_block);
  status_poll_c: cover property (state == SFE_STAT && io1_oe && array_busy);
endmodule : sfe_top

// ===== shared/sfe_pkg.sv
// Shared constants, opcodes and state codes of the serial flash front end
package sfe_pkg;
  localparam int SFE_ADDR_W = 19;
  localparam int SFE_BLK_LSB = 16;
  localparam int SFE_BLK_W = 3;
  localparam logic [SFE_ADDR_W-1:0] SFE_SECTOR_MASK = 19'h7F000;
  localparam logic [SFE_ADDR_W-1:0] SFE_BLOCK_MASK = 19'h70000;
  localparam logic [1:0] SFE_ADDR_LAST = 2'h2;
  localparam logic [7:0] SFE_OP_RDSR = 8'h05;
  localparam logic [7:0] SFE_OP_WREN = 8'h06;
  localparam logic [7:0] SFE_OP_WRDI = 8'h04;
  localparam logic [7:0] SFE_OP_WRSR = 8'h01;
  localparam logic [7:0] SFE_OP_SE = 8'h20;
  localparam logic [7:0] SFE_OP_BE = 8'hD8;
  localparam logic [7:0] SFE_OP_FRD_DO = 8'h3B;
  localparam logic [7:0] SFE_OP_FRD_DIO = 8'hBB;
  localparam int SFE_ST_BUSY = 0;
  localparam int SFE_ST_WEL = 1;
  localparam int SFE_ST_BP_LSB = 2;
  localparam int SFE_ST_TB = 5;
  localparam int SFE_ST_BPL = 7;
  localparam logic [2:0] SFE_BP_RESET = 3'h0;
  localparam logic SFE_TB_RESET = 1'b0;
  localparam logic SFE_BPL_RESET = 1'b0;
  localparam logic SFE_WEL_RESET = 1'b0;
  localparam logic [2:0] SFE_BITS_ONE = 3'h1;
  localparam logic [2:0] SFE_BITS_TWO = 3'h2;
  localparam logic [2:0] SFE_LAST_BIT_SINGLE = 3'h7;
  localparam logic [2:0] SFE_LAST_BIT_DUAL = 3'h6;

  typedef enum logic [7:0] {
    SFE_IDLE  = 8'h01,
    SFE_CMD   = 8'h02,
    SFE_ADDR  = 8'h04,
    SFE_DUMMY = 8'h08,
    SFE_DOUT  = 8'h10,
    SFE_STAT  = 8'h20,
    SFE_WRSR  = 8'h40,
    SFE_IGN   = 8'h80
  } sfe_state_type;
endpackage : sfe_pkg

// ===== shared/sfe_prot_if.sv
// Carrier between the front end and its block protection check
`timescale 1ns/1ps
interface sfe_prot_if;
  import sfe_pkg::*;
  logic [2:0] bp;
  logic tb;
  logic [SFE_BLK_W-1:0] blk;
  logic hit;
  modport req (output bp, output tb, output blk, input hit);
  modport chk (input bp, input tb, input blk, output hit);
endinterface : sfe_prot_if

// ===== test/sfe_master.sv
// Bus master model driving the serial link in mode 0 or mode 3
`timescale 1ns/1ps
module sfe_master #(
  parameter int HALF = 6
) (
  input wire logic clk,
  input wire logic w0,
  input wire logic w1,
  output logic sck,
  output logic cs_n,
  output logic hold_n,
  output logic m_d0,
  output logic m_d1,
  output logic m_oe0,
  output logic m_oe1
);
  logic mode3;
  initial begin
    mode3 = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    m_d0 = 1'b0;
    m_d1 = 1'b0;
    m_oe0 = 1'b0;
    m_oe1 = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  // Idle level of sck sets the mode; cs_n then stays low to the end of the frame
  task automatic start(input logic m3);
    mode3 = m3;
    sck = m3;
    wait_clk(HALF);
    cs_n = 1'b0;
    wait_clk(HALF);
  endtask : start
  task automatic stop();
    m_oe0 = 1'b0;
    m_oe1 = 1'b0;
    sck = mode3;
    wait_clk(HALF);
    cs_n = 1'b1;
    wait_clk(2 * HALF);
  endtask : stop
  // Data moves only while sck is low, so the rise always finds it settled
  task automatic byte_io(input logic [7:0] tx, input logic dual, input logic drv,
                         output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int k = 0; k < (dual ? 4 : 8); k++) begin
      sck = 1'b0;
      m_oe0 = drv;
      m_oe1 = drv & dual;
      m_d1 = sh[7];
      m_d0 = dual ? sh[6] : sh[7];
      sh = dual ? sh << 2 : sh << 1;
      wait_clk(HALF);
      rx = dual ? {rx[5:0], w1, w0} : {rx[6:0], w1};
      sck = 1'b1;
      wait_clk(HALF);
    end
  endtask : byte_io
  // Hold edges only while sck is low
  task automatic hold_on();
    sck = 1'b0;
    wait_clk(HALF);
    hold_n = 1'b0;
    wait_clk(2 * HALF);
  endtask : hold_on
  task automatic hold_off();
    m_oe0 = 1'b0;
    m_oe1 = 1'b0;
    sck = 1'b0;
    wait_clk(HALF);
    hold_n = 1'b1;
    wait_clk(HALF);
  endtask : hold_off
endmodule : sfe_master

// ===== test/testbench.sv
// Self-checking testbench of the serial flash front end
`timescale 1ns/1ps
module testbench;
  import sfe_pkg::*;
  logic clk, rst, wp_n, array_busy, flt, sck, cs_n, hold_n, w0, w1;
  logic m_d0, m_d1, m_oe0, m_oe1, io0_out, io0_oe, io1_out, io1_oe;
  logic erase_sector, erase_block, standby;
  logic [7:0] rd_data, rx;
  logic [SFE_ADDR_W-1:0] rd_addr, erase_addr;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_sec = 0;
  int n_blk = 0;
  // A line nobody drives must not look like a stable value
  assign w0 = io0_oe ? io0_out : (m_oe0 ? m_d0 : flt);
  assign w1 = io1_oe ? io1_out : (m_oe1 ? m_d1 : ~flt);
  sfe_top sfe_top_i (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
    .wp_n(wp_n), .io0_in(w0), .io0_out(io0_out), .io0_oe(io0_oe), .io1_in(w1),
    .io1_out(io1_out), .io1_oe(io1_oe), .array_busy(array_busy), .rd_data(rd_data),
    .rd_addr(rd_addr), .erase_sector(erase_sector), .erase_block(erase_block),
    .erase_addr(erase_addr), .standby(standby));
  sfe_master sfe_master_i (.clk(clk), .w0(w0), .w1(w1), .sck(sck), .cs_n(cs_n),
    .hold_n(hold_n), .m_d0(m_d0), .m_d1(m_d1), .m_oe0(m_oe0), .m_oe1(m_oe1));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] array_byte(input logic [18:0] a);
    return a[7:0] ^ {1'b0, a[18:12]} ^ 8'h5A;
  endfunction : array_byte
  always @(negedge clk) begin
    flt <= ~flt;
    rd_data <= array_byte(rd_addr);
  end
  always @(posedge clk) begin
    if (erase_sector === 1'b1) n_sec++;
    if (erase_block === 1'b1) n_blk++;
  end
  task automatic chk_val(input string what, input logic [18:0] exp, input logic [18:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb);
    sfe_master_i.start(1'b0);
    sfe_master_i.byte_io(op, 1'b0, 1'b1, rx);
    for (int i = nb - 1; i >= 0; i--) sfe_master_i.byte_io(a[i*8 +: 8], 1'b0, 1'b1, rx);
    sfe_master_i.stop();
  endtask : cmd
  task automatic st(input logic m3, input logic [7:0] exp);
    sfe_master_i.start(m3);
    sfe_master_i.byte_io(SFE_OP_RDSR, 1'b0, 1'b1, rx);
    sfe_master_i.byte_io(8'h00, 1'b0, 1'b1, rx);
    sfe_master_i.stop();
    chk_val("status", {11'h0, exp}, {11'h0, rx});
  endtask : st
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int np,
                       input logic [18:0] ea);
    int s0, b0;
    s0 = n_sec;
    b0 = n_blk;
    cmd(op, a, 3);
    sfe_master_i.wait_clk(8);
    chk_val("erase pulses", 19'(np), 19'((op == SFE_OP_SE) ? n_sec - s0 : n_blk - b0));
    if (np > 0) chk_val("erase address", ea, erase_addr);
  endtask : erase
  task automatic fread(input logic m3, input logic [7:0] op, input logic [23:0] a,
                       input logic hold);
    logic d;
    d = (op == SFE_OP_FRD_DIO);
    sfe_master_i.start(m3);
    sfe_master_i.byte_io(op, 1'b0, 1'b1, rx);
    for (int i = 2; i >= 0; i--) begin
      if (hold && i == 0) begin
        sfe_master_i.hold_on();
        sfe_master_i.byte_io(8'hFF, 1'b1, 1'b1, rx);
        sfe_master_i.hold_off();
      end
      sfe_master_i.byte_io(a[i*8 +: 8], d, 1'b1, rx);
    end
    sfe_master_i.byte_io(8'h00, d, 1'b1, rx);
    for (int j = 0; j < 2; j++) begin
      sfe_master_i.byte_io(8'h00, 1'b1, 1'b0, rx);
      chk_val("read byte", {11'h0, array_byte(a[18:0] + 19'(j))}, {11'h0, rx});
    end
    sfe_master_i.stop();
  endtask : fread
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    array_busy = 1'b0;
    flt = 1'b0;
    rd_data = 8'h00;
    repeat (5) @(negedge clk);
    chk_flag("standby in reset", 1'b1, standby);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_flag("standby idle", 1'b1, standby);
    st(1'b0, 8'h00);
    st(1'b1, 8'h00);
    cmd(SFE_OP_WREN, 24'h0, 0);
    st(1'b0, 8'h02);
    cmd(SFE_OP_WRDI, 24'h0, 0);
    st(1'b1, 8'h00);
    // A second opcode in the same frame must not run
    sfe_master_i.start(1'b0);
    sfe_master_i.byte_io(8'hFF, 1'b0, 1'b1, rx);
    sfe_master_i.byte_io(SFE_OP_WREN, 1'b0, 1'b1, rx);
    chk_flag("standby selected", 1'b0, standby);
    sfe_master_i.stop();
    st(1'b0, 8'h00);
    array_busy = 1'b1;
    st(1'b0, 8'h01);
    cmd(SFE_OP_WREN, 24'h0, 0);
    st(1'b0, 8'h01);
    array_busy = 1'b0;
    st(1'b0, 8'h00);
    erase(SFE_OP_SE, 24'h012345, 0, 19'h0);
    cmd(SFE_OP_WREN, 24'h0, 0);
    erase(SFE_OP_SE, 24'h053ABC, 1, 19'h53000);
    st(1'b0, 8'h00);
    cmd(SFE_OP_WREN, 24'h0, 0);
    erase(SFE_OP_BE, 24'h067FFF, 1, 19'h60000);
    cmd(SFE_OP_WREN, 24'h0, 0);
    cmd(SFE_OP_WRSR, 24'h04, 1);
    st(1'b0, 8'h04);
    cmd(SFE_OP_WREN, 24'h0, 0);
    erase(SFE_OP_SE, 24'h071000, 0, 19'h0);
    st(1'b0, 8'h04);
    cmd(SFE_OP_WREN, 24'h0, 0);
    erase(SFE_OP_BE, 24'h00FFFF, 1, 19'h00000);
    cmd(SFE_OP_WREN, 24'h0, 0);
    cmd(SFE_OP_WRSR, 24'h84, 1);
    st(1'b0, 8'h84);
    wp_n = 1'b0;
    cmd(SFE_OP_WREN, 24'h0, 0);
    cmd(SFE_OP_WRSR, 24'h00, 1);
    st(1'b0, 8'h84);
    wp_n = 1'b1;
    cmd(SFE_OP_WREN, 24'h0, 0);
    cmd(SFE_OP_WRSR, 24'h00, 1);
    st(1'b0, 8'h00);
    fread(1'b1, SFE_OP_FRD_DO, 24'h012345, 1'b1);
    fread(1'b0, SFE_OP_FRD_DIO, 24'h07FFFE, 1'b0);
    // Output must float while held in the middle of a status read
    sfe_master_i.start(1'b0);
    sfe_master_i.byte_io(SFE_OP_RDSR, 1'b0, 1'b1, rx);
    sfe_master_i.byte_io(8'h00, 1'b0, 1'b1, rx);
    chk_flag("out enable driving", 1'b1, io1_oe);
    sfe_master_i.hold_on();
    chk_flag("out enable held", 1'b0, io1_oe);
    sfe_master_i.hold_off();
    sfe_master_i.stop();
    chk_flag("standby after frame", 1'b1, standby);
    give_verdict();
  end
endmodule : testbench
